/* File: logic/jcm_pkg.sv */
package jcm_pkg;

    // ------------------------------------------------------------
    // Register map, byte addresses on the APB
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_INSTR = 8'h00;
    localparam logic [7:0] ADDR_PC = 8'h04;
    localparam logic [7:0] ADDR_SRC = 8'h08;
    localparam logic [7:0] ADDR_DST = 8'h0c;
    localparam logic [7:0] ADDR_DNEXT = 8'h10;
    localparam logic [7:0] ADDR_BASE = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;
    localparam logic [7:0] ADDR_CTRL = 8'h1c;
    localparam logic [7:0] ADDR_RES_HI = 8'h20;
    localparam logic [7:0] ADDR_RES_LO = 8'h24;
    localparam logic [7:0] ADDR_INFO = 8'h28;

    localparam int CTRL_GO_BIT = 0;
    localparam int CTRL_BUSY_BIT = 0;
    localparam int CTRL_DONE_BIT = 1;
    localparam int CTRL_ILLEGAL_BIT = 2;

    localparam int INFO_AUTOINC_LSB = 0;
    localparam int INFO_BYTE = 2;
    localparam int INFO_WR_HI = 3;
    localparam int INFO_WR_LO = 4;
    localparam int INFO_LO_MEM = 5;
    localparam int INFO_JUMPED = 6;
    localparam int INFO_W = 7;

    // ------------------------------------------------------------
    // Status bits, bit n of the status register is STn
    // ------------------------------------------------------------
    localparam int ST_W = 6;
    localparam int ST_LGT = 0;
    localparam int ST_AGT = 1;
    localparam int ST_EQ = 2;
    localparam int ST_CARRY = 3;
    localparam int ST_OVF = 4;
    localparam int ST_PAR = 5;

    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [5:0] RST_STATUS = 6'h00;

    // ------------------------------------------------------------
    // Opcodes
    // ------------------------------------------------------------
    localparam logic [7:0] OP8_JUMP_FIRST = 8'h10;
    localparam logic [7:0] OP8_JUMP_LAST = 8'h1c;
    localparam logic [7:0] OP8_SET_ONE = 8'h1d;
    localparam logic [7:0] OP8_SET_ZERO = 8'h1e;
    localparam logic [7:0] OP8_TEST = 8'h1f;
    localparam logic [5:0] OP6_COC = 6'h08;
    localparam logic [5:0] OP6_CZC = 6'h09;
    localparam logic [5:0] OP6_XOR = 6'h0a;
    localparam logic [5:0] OP6_LOAD_IO = 6'h0c;
    localparam logic [5:0] OP6_STORE_IO = 6'h0d;
    localparam logic [5:0] OP6_UNSIGNED_MULTIPLY = 6'h0e;
    localparam logic [5:0] OP6_DIV = 6'h0f;

    localparam logic [3:0] JC_ALWAYS = 4'h0;
    localparam logic [3:0] JC_LESS = 4'h1;
    localparam logic [3:0] JC_LESS_EQ = 4'h2;
    localparam logic [3:0] JC_EQUAL = 4'h3;
    localparam logic [3:0] JC_HIGH_EQ = 4'h4;
    localparam logic [3:0] JC_GREATER = 4'h5;
    localparam logic [3:0] JC_NOT_EQ = 4'h6;
    localparam logic [3:0] JC_NO_CARRY = 4'h7;
    localparam logic [3:0] JC_CARRY = 4'h8;
    localparam logic [3:0] JC_NO_OVF = 4'h9;
    localparam logic [3:0] JC_LOW = 4'ha;
    localparam logic [3:0] JC_HIGH = 4'hb;
    localparam logic [3:0] JC_ODD = 4'hc;

    localparam logic [1:0] TS_AUTOINC = 2'h3;
    localparam logic [3:0] LAST_WS_REG = 4'hf;
    localparam logic [3:0] BYTE_COUNT_MAX = 4'h8;
    localparam logic [3:0] DIV_LAST_STEP = 4'hf;
    localparam int IO_AW = 12;

    typedef enum logic [5:0] {
        S_IDLE = 6'h01,
        S_EXEC = 6'h02,
        S_IO = 6'h04,
        S_CAP = 6'h08,
        S_FIN = 6'h10,
        S_DIV = 6'h20
    } jcm_state_t;

endpackage : jcm_pkg

/* File: logic/jcm_exec.sv */
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/10ps
// Contract
// - Byte operands use the register left byte
// - Taken jump adds displacement, status untouched
// - Displacement is signed word count
// - Equal, not-equal, greater, less, always conditions
// - High, high-equal, low, low-equal conditions
// - Carry, no-carry, no-overflow, odd-parity conditions
// - Single bit address is base plus displacement
// - Set bit one or zero, status kept
// - Test bit copies input into equal
// - Compare-ones sets equal on subset
// - Compare-zeros sets equal on disjoint
// - Exclusive OR writes destination, status 0-2
// - Unsigned multiply, high then low half
// - Divide overflow when source not above destination
// - Divide pair: quotient and remainder
// - Multibit count zero means sixteen
// - Bits serial from base, incrementing address
// - Byte source for counts one to eight
// - Autoincrement by one or two
// - Load sends from operand LSB first
// - Store fills from LSB, zeros elsewhere
// - Multibit status 0-2, parity only bytes
// - Jump opcodes 1000 through 1c00
module jcm_exec
    import jcm_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    output logic [IO_AW-1:0] io_addr_o,
    output logic io_wr_o,
    output logic io_wdata_o,
    output logic io_rd_o,
    input wire logic io_bit_i
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [2:0] stat3(input logic [15:0] v);
        stat3 = {v == 16'h0000, ($signed(v) > $signed(16'h0000)), v != 16'h0000};
    endfunction : stat3

    function automatic logic jump_taken(input logic [3:0] code, input logic [5:0] st);
        case (code)
            JC_ALWAYS: jump_taken = 1'b1;
            JC_LESS: jump_taken = ~st[ST_AGT] & ~st[ST_EQ];
            JC_LESS_EQ: jump_taken = ~st[ST_LGT] | st[ST_EQ];
            JC_EQUAL: jump_taken = st[ST_EQ];
            JC_HIGH_EQ: jump_taken = st[ST_LGT] | st[ST_EQ];
            JC_GREATER: jump_taken = st[ST_AGT];
            JC_NOT_EQ: jump_taken = ~st[ST_EQ];
            JC_NO_CARRY: jump_taken = ~st[ST_CARRY];
            JC_CARRY: jump_taken = st[ST_CARRY];
            JC_NO_OVF: jump_taken = ~st[ST_OVF];
            JC_LOW: jump_taken = ~st[ST_LGT] & ~st[ST_EQ];
            JC_HIGH: jump_taken = st[ST_LGT] & ~st[ST_EQ];
            JC_ODD: jump_taken = st[ST_PAR];
            default: jump_taken = 1'b0;
        endcase
    endfunction : jump_taken

    jcm_state_t state;
    logic [15:0] instr, pc, src, dst, dnext, base;
    logic [5:0] status;
    logic [15:0] res_hi, res_lo, gather;
    logic [INFO_W-1:0] info;
    logic done, illegal, single;
    logic [3:0] io_idx, io_last, div_step;
    logic [16:0] rem;
    logic [15:0] quo;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire [7:0] op8 = instr[15:8];
    wire [5:0] op6 = instr[15:10];
    wire [3:0] cnt = instr[9:6];
    wire [1:0] ts = instr[5:4];
    wire is_jump = (op8 >= OP8_JUMP_FIRST) && (op8 <= OP8_JUMP_LAST);
    wire is_single = (op8 == OP8_SET_ONE) || (op8 == OP8_SET_ZERO) || (op8 == OP8_TEST);
    wire is_test = op8 == OP8_TEST;
    wire is_coc = op6 == OP6_COC;
    wire is_czc = op6 == OP6_CZC;
    wire is_xor = op6 == OP6_XOR;
    wire is_load = op6 == OP6_LOAD_IO;
    wire is_store = op6 == OP6_STORE_IO;
    wire is_multi = is_load | is_store;
    wire is_unsigned_multiply = op6 == OP6_UNSIGNED_MULTIPLY;
    wire is_div = op6 == OP6_DIV;
    wire taken = jump_taken(instr[11:8], status);
    // Displacement counts words, so it is doubled
    wire [15:0] jump_off = {{7{instr[7]}}, instr[7:0], 1'b0};
    wire [IO_AW-1:0] io_disp = {{(IO_AW-8){instr[7]}}, instr[7:0]};
    wire [IO_AW-1:0] io_base = base[12:1];
    wire coc_hit = (src & dst) == src;
    wire czc_hit = (src & dst) == 16'h0000;
    wire [15:0] xor_res = src ^ dst;
    wire [31:0] prod = 32'(src) * 32'(dst);
    wire dst_is_last = cnt == LAST_WS_REG;
    wire div_ovf = src <= dst;

    // ------------------------------------------------------------
    // Serial I/O walk
    // ------------------------------------------------------------
    wire mb_byte = (cnt != 4'h0) && (cnt <= BYTE_COUNT_MAX);
    wire [15:0] xfer = mb_byte ? {8'h00, src[15:8]} : src;
    wire [IO_AW-1:0] io_bit_addr = io_base + io_disp;
    wire [IO_AW-1:0] io_addr_cur = single ? io_bit_addr : io_base + {8'h00, io_idx};
    wire io_is_wr = single ? ~is_test : is_load;
    wire io_wbit = single ? (op8 == OP8_SET_ONE) : xfer[io_idx];
    // Byte results stay left justified so the compare sees byte sign
    wire [15:0] load_res = mb_byte ? {src[15:8], 8'h00} : src;
    wire [15:0] store_res = mb_byte ? {gather[7:0], 8'h00} : gather;
    wire [15:0] multi_res = is_store ? store_res : load_res;
    wire [1:0] autoinc = (ts != TS_AUTOINC) ? 2'h0 : (mb_byte ? 2'h1 : 2'h2);

    // ------------------------------------------------------------
    // Divide step, one quotient bit per cycle
    // ------------------------------------------------------------
    wire [16:0] rem_sh = {rem[15:0], quo[15]};
    wire div_ge = rem_sh >= {1'b0, src};
    wire [16:0] rem_next = div_ge ? (rem_sh - {1'b0, src}) : rem_sh;
    wire [15:0] quo_next = {quo[14:0], div_ge};

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    wire busy = state != S_IDLE;
    wire setup = psel_i & ~penable_i;
    wire acc = psel_i & penable_i & pready_o & ~pslverr_o;
    wire wr_acc = acc & pwrite_i;
    wire ro_addr = (paddr_i == ADDR_RES_HI) | (paddr_i == ADDR_RES_LO) | (paddr_i == ADDR_INFO);
    wire mapped = (paddr_i[1:0] == 2'h0) && (paddr_i <= ADDR_INFO);
    // Operands must not move under a running instruction
    wire bad = ~mapped | (pwrite_i & (busy | ro_addr));
    wire go_wr = wr_acc & (paddr_i == ADDR_CTRL) & pwdata_i[CTRL_GO_BIT];
    wire [15:0] ctrl_rd = {13'h0000, illegal, done, busy};
    wire [15:0] rd_word =
        (paddr_i == ADDR_INSTR) ? instr :
        (paddr_i == ADDR_PC) ? pc :
        (paddr_i == ADDR_SRC) ? src :
        (paddr_i == ADDR_DST) ? dst :
        (paddr_i == ADDR_DNEXT) ? dnext :
        (paddr_i == ADDR_BASE) ? base :
        (paddr_i == ADDR_STATUS) ? {10'h000, status} :
        (paddr_i == ADDR_CTRL) ? ctrl_rd :
        (paddr_i == ADDR_RES_HI) ? res_hi :
        (paddr_i == ADDR_RES_LO) ? res_lo :
        (paddr_i == ADDR_INFO) ? {9'h000, info} : 16'h0000;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
        end else begin
            pready_o <= setup;
            pslverr_o <= setup & bad;
            if (setup) begin
                prdata_o <= {16'h0000, rd_word};
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            instr <= RST_WORD;
            src <= RST_WORD;
            dst <= RST_WORD;
            dnext <= RST_WORD;
            base <= RST_WORD;
        end else if (wr_acc) begin
            if (paddr_i == ADDR_INSTR) instr <= pwdata_i[15:0];
            if (paddr_i == ADDR_SRC) src <= pwdata_i[15:0];
            if (paddr_i == ADDR_DST) dst <= pwdata_i[15:0];
            if (paddr_i == ADDR_DNEXT) dnext <= pwdata_i[15:0];
            if (paddr_i == ADDR_BASE) base <= pwdata_i[15:0];
        end
    end

    // ------------------------------------------------------------
    // Execution sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state <= S_IDLE;
            pc <= RST_WORD;
            status <= RST_STATUS;
            res_hi <= RST_WORD;
            res_lo <= RST_WORD;
            info <= '0;
            done <= 1'b0;
            illegal <= 1'b0;
            single <= 1'b0;
            io_addr_o <= '0;
            io_wr_o <= 1'b0;
            io_wdata_o <= 1'b0;
            io_rd_o <= 1'b0;
            io_idx <= 4'h0;
            io_last <= 4'h0;
            gather <= RST_WORD;
            rem <= 17'h00000;
            quo <= RST_WORD;
            div_step <= 4'h0;
        end else begin
            case (state)
                S_IDLE: begin
                    if (wr_acc && paddr_i == ADDR_PC) pc <= pwdata_i[15:0];
                    if (wr_acc && paddr_i == ADDR_STATUS) status <= pwdata_i[5:0];
                    if (go_wr) begin
                        state <= S_EXEC;
                        done <= 1'b0;
                        illegal <= 1'b0;
                        info <= '0;
                    end
                end
                S_EXEC: begin
                    state <= S_IDLE;
                    done <= 1'b1;
                    if (is_jump) begin
                        if (taken) pc <= pc + jump_off;
                        info[INFO_JUMPED] <= taken;
                    end else if (is_single) begin
                        single <= 1'b1;
                        io_idx <= 4'h0;
                        io_last <= 4'h0;
                        gather <= RST_WORD;
                        state <= S_IO;
                        done <= 1'b0;
                    end else if (is_coc) begin
                        status[ST_EQ] <= coc_hit;
                    end else if (is_czc) begin
                        status[ST_EQ] <= czc_hit;
                    end else if (is_xor) begin
                        res_hi <= xor_res;
                        status[2:0] <= stat3(xor_res);
                        info[INFO_WR_HI] <= 1'b1;
                    end else if (is_unsigned_multiply) begin
                        res_hi <= prod[31:16];
                        res_lo <= prod[15:0];
                        info[INFO_WR_HI] <= 1'b1;
                        info[INFO_WR_LO] <= 1'b1;
                        info[INFO_LO_MEM] <= dst_is_last;
                    end else if (is_multi) begin
                        single <= 1'b0;
                        io_idx <= 4'h0;
                        io_last <= cnt - 4'h1;
                        gather <= RST_WORD;
                        info[INFO_AUTOINC_LSB +: 2] <= autoinc;
                        info[INFO_BYTE] <= mb_byte;
                        state <= S_IO;
                        done <= 1'b0;
                    end else if (is_div) begin
                        if (div_ovf) begin
                            status[ST_OVF] <= 1'b1;
                        end else begin
                            status[ST_OVF] <= 1'b0;
                            rem <= {1'b0, dst};
                            quo <= dnext;
                            div_step <= 4'h0;
                            state <= S_DIV;
                            done <= 1'b0;
                        end
                    end else begin
                        illegal <= 1'b1;
                    end
                end
                S_IO: begin
                    io_addr_o <= io_addr_cur;
                    io_wr_o <= io_is_wr;
                    io_wdata_o <= io_wbit;
                    io_rd_o <= ~io_is_wr;
                    state <= S_CAP;
                end
                S_CAP: begin
                    io_wr_o <= 1'b0;
                    io_rd_o <= 1'b0;
                    if (io_rd_o) gather[io_idx] <= io_bit_i;
                    if (io_idx == io_last) begin
                        state <= S_FIN;
                    end else begin
                        io_idx <= io_idx + 4'h1;
                        state <= S_IO;
                    end
                end
                S_FIN: begin
                    state <= S_IDLE;
                    done <= 1'b1;
                    if (single) begin
                        if (is_test) status[ST_EQ] <= gather[0];
                    end else begin
                        status[2:0] <= stat3(multi_res);
                        if (mb_byte) status[ST_PAR] <= ^multi_res[15:8];
                        if (is_store) begin
                            res_hi <= multi_res;
                            info[INFO_WR_HI] <= 1'b1;
                        end
                    end
                end
                S_DIV: begin
                    rem <= rem_next;
                    quo <= quo_next;
                    div_step <= div_step + 4'h1;
                    if (div_step == DIV_LAST_STEP) begin
                        res_hi <= quo_next;
                        res_lo <= rem_next[15:0];
                        info[INFO_WR_HI] <= 1'b1;
                        info[INFO_WR_LO] <= 1'b1;
                        info[INFO_LO_MEM] <= dst_is_last;
                        state <= S_IDLE;
                        done <= 1'b1;
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_jump_target;
        @(posedge clk_i) disable iff (reset_i)
        (state == S_EXEC && is_jump && taken) |=> pc == $past(pc) + $past(jump_off);
    endproperty
    a_jump_target: assert property (p_jump_target) else $error("jump target wrong");

    property p_jump_status;
        @(posedge clk_i) disable iff (reset_i)
        (state == S_EXEC && is_jump) |=> $stable(status) && (taken || $stable(pc));
    endproperty
    a_jump_status: assert property (p_jump_status) else $error("jump side effect");

    property p_jump_equal;
        @(posedge clk_i) disable iff (reset_i)
        (is_jump && instr[11:8] == JC_EQUAL) |-> taken == status[ST_EQ];
    endproperty
    a_jump_equal: assert property (p_jump_equal) else $error("equal test wrong");

    property p_jump_high;
        @(posedge clk_i) disable iff (reset_i)
        (is_jump && instr[11:8] == JC_HIGH) |-> taken == (status[ST_LGT] & ~status[ST_EQ]);
    endproperty
    a_jump_high: assert property (p_jump_high) else $error("high test wrong");

    property p_jump_carry;
        @(posedge clk_i) disable iff (reset_i)
        (is_jump && instr[11:8] == JC_CARRY) |-> taken == status[ST_CARRY];
    endproperty
    a_jump_carry: assert property (p_jump_carry) else $error("carry test wrong");

    property p_set_one;
        @(posedge clk_i) disable iff (reset_i)
        (state == S_EXEC && op8 == OP8_SET_ONE)
            |-> ##2 (io_wr_o && io_wdata_o && io_addr_o == $past(io_bit_addr, 2));
    endproperty
    a_set_one: assert property (p_set_one) else $error("set bit wrong");

    property p_test_bit;
        @(posedge clk_i) disable iff (reset_i)
        (state == S_CAP && single && is_test && io_rd_o) |=> ##1 status[ST_EQ] == $past(io_bit_i, 2);
    endproperty
    a_test_bit: assert property (p_test_bit) else $error("test bit lost");

    property p_coc;
        @(posedge clk_i) disable iff (reset_i)
        (state == S_EXEC && is_coc) |=> status[ST_EQ] == $past(coc_hit);
    endproperty
    a_coc: assert property (p_coc) else $error("compare ones wrong");

    property p_unsigned_multiply;
        @(posedge clk_i) disable iff (reset_i)
        (state == S_EXEC && is_unsigned_multiply)
            |=> {res_hi, res_lo} == $past(src) * $past(dst) && $stable(status);
    endproperty
    a_unsigned_multiply: assert property (p_unsigned_multiply) else $error("multiply wrong");

    property p_div_ovf;
        @(posedge clk_i) disable iff (reset_i)
        (state == S_EXEC && is_div && div_ovf) |=> status[ST_OVF] && state == S_IDLE && $stable(res_hi);
    endproperty
    a_div_ovf: assert property (p_div_ovf) else $error("divide overflow wrong");

    property p_count16;
        @(posedge clk_i) disable iff (reset_i)
        (state == S_EXEC && is_multi && cnt == 4'h0) |=> io_last == 4'hf && !info[INFO_BYTE];
    endproperty
    a_count16: assert property (p_count16) else $error("count zero wrong");

    property p_word_parity;
        @(posedge clk_i) disable iff (reset_i)
        (state == S_FIN && !single && !mb_byte) |=> status[ST_PAR] == $past(status[ST_PAR]);
    endproperty
    a_word_parity: assert property (p_word_parity) else $error("parity touched");

endmodule : jcm_exec

/* File: bench/jcm_io_model.sv */
`timescale 1ns/10ps
module jcm_io_model (
    input wire logic clk_i,
    input wire logic [11:0] io_addr_i,
    input wire logic io_wr_i,
    input wire logic io_wdata_i,
    input wire logic io_rd_i,
    output logic io_bit_o
);
    logic out_bits [0:4095];
    logic last_bit = 1'b0;
    // Outside a read the line toggles, so a late sample never looks valid
    assign io_bit_o = io_rd_i ? (io_addr_i[0] ^ io_addr_i[2]) : ~last_bit;
    always @(posedge clk_i) begin
        last_bit <= io_bit_o;
        if (io_wr_i) begin
            out_bits[io_addr_i] <= io_wdata_i;
        end
    end
endmodule : jcm_io_model

/* File: bench/jcm_exec_test.sv */
`timescale 1ns/10ps
module jcm_exec_test;
    import jcm_pkg::*;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0;
    logic [31:0] prdata_o;
    logic pready_o, pslverr_o, io_wr_o, io_wdata_o, io_rd_o, io_bit_i;
    logic [IO_AW-1:0] io_addr_o;
    int fails = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [31:0] rd;
    logic err;
    // Row: instr src dst dnext pc hi lo {check_hi_lo, st} expected_st
    logic [127:0] rows [0:23];
    jcm_exec uut (.clk_i(clk_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .io_addr_o(io_addr_o), .io_wr_o(io_wr_o),
        .io_wdata_o(io_wdata_o), .io_rd_o(io_rd_o), .io_bit_i(io_bit_i));
    jcm_io_model io_space (.clk_i(clk_i), .io_addr_i(io_addr_o), .io_wr_i(io_wr_o),
        .io_wdata_i(io_wdata_o), .io_rd_i(io_rd_o), .io_bit_o(io_bit_i));
    initial begin
        forever #2 clk_i = ~clk_i;
    end
    task automatic test_done();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done
    always @(posedge clk_i) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            fails++;
            test_done();
        end
    end
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
            fails++;
        end
    endtask : chk
    // ------------------------------------------------------------
    // Bus cycles
    // ------------------------------------------------------------
    task automatic apb(input logic wr, input logic [7:0] a, input logic [15:0] d);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        paddr_i <= a;
        pwrite_i <= wr;
        pwdata_i <= {16'h0000, d};
        @(posedge clk_i);
        penable_i <= 1'b1;
        // This wait ends when pready_o rises, or at the bench timeout if it never does
        do begin
            @(posedge clk_i);
        end while (pready_o !== 1'b1);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_i);
    endtask : apb
    task automatic run(input logic [127:0] r);
        apb(1'b1, ADDR_INSTR, r[127:112]);
        apb(1'b1, ADDR_SRC, r[111:96]);
        apb(1'b1, ADDR_DST, r[95:80]);
        apb(1'b1, ADDR_DNEXT, r[79:64]);
        apb(1'b1, ADDR_PC, 16'h0100);
        apb(1'b1, ADDR_BASE, 16'h0200);
        apb(1'b1, ADDR_STATUS, {10'h000, r[13:8]});
        apb(1'b1, ADDR_CTRL, 16'h0001);
        do begin
            apb(1'b0, ADDR_CTRL, 16'h0000);
        end while (rd[CTRL_DONE_BIT] !== 1'b1);
    endtask : run
    initial begin
        repeat (20) @(posedge clk_i);
        reset_i <= 1'b0;
        @(posedge clk_i);
        apb(1'b0, ADDR_STATUS, 16'h0000);
        chk("status after reset", 16'h0000, rd[15:0]);
        apb(1'b0, 8'h40, 16'h0000);
        chk("unmapped refused", 16'h0001, {15'h0000, err});
        rows = '{128'h10ff_0000_0000_0000_00fe_0000_0000_3f3f, 128'h137f_0000_0000_0000_01fe_0000_0000_0404,
            128'h1601_0000_0000_0000_0100_0000_0000_0404, 128'h1180_0000_0000_0000_0000_0000_0000_0000,
            128'h1501_0000_0000_0000_0102_0000_0000_0202, 128'h1b01_0000_0000_0000_0102_0000_0000_0101,
            128'h1a01_0000_0000_0000_0100_0000_0000_0101, 128'h1401_0000_0000_0000_0102_0000_0000_0404,
            128'h1201_0000_0000_0000_0100_0000_0000_0101, 128'h1701_0000_0000_0000_0100_0000_0000_0808,
            128'h1801_0000_0000_0000_0102_0000_0000_0808, 128'h1901_0000_0000_0000_0100_0000_0000_1010,
            128'h1c01_0000_0000_0000_0102_0000_0000_2020, 128'h2000_aa0c_efcd_0000_0100_0000_0000_0004,
            128'h2400_aa0c_5530_0000_0100_0000_0000_0004, 128'h2400_aa0c_0008_0000_0100_0000_0000_0400,
            128'h2800_00ff_00ff_0000_0100_0000_0000_b83c, 128'h2800_8000_0000_0000_0100_8000_0000_b839,
            128'h3800_ffff_ffff_0000_0100_fffe_0001_d515, 128'h3c00_0002_0001_0001_0100_8000_0001_d000,
            128'h3c00_0001_0001_0000_0100_0000_0000_0010, 128'h30f0_a55a_0000_0000_0100_0000_0000_0001,
            128'h3430_0000_0000_0000_0100_5a5a_0002_6023, 128'h3570_0000_0000_0000_0100_1a00_0005_4023};
        foreach (rows[i]) begin
            run(rows[i]);
            apb(1'b0, ADDR_PC, 16'h0000);
            chk("pc", rows[i][63:48], rd[15:0]);
            apb(1'b0, ADDR_STATUS, 16'h0000);
            chk("status", {8'h00, rows[i][7:0]}, rd[15:0]);
            if (rows[i][15] | rows[i][14]) begin
                apb(1'b0, ADDR_RES_HI, 16'h0000);
                chk("result high", rows[i][47:32], rd[15:0]);
            end
            if (rows[i][14]) begin
                apb(1'b0, rows[i][15] ? ADDR_RES_LO : ADDR_INFO, 16'h0000);
                chk("low or info", rows[i][31:16], rows[i][15] ? rd[15:0] : {13'h0, rd[2:0]});
            end
        end
        chk("load bits", 16'h0005, {13'h0, io_space.out_bits[12'h102], io_space.out_bits[12'h101],
            io_space.out_bits[12'h100]});
        for (int j = 0; j < 2; j++) begin
            run({j ? 16'h1d04 : 16'h1e04, 96'h0, 16'h2a2a});
            chk("single bit out", 16'(j), {15'h0, io_space.out_bits[12'h104]});
            apb(1'b0, ADDR_STATUS, 16'h0000);
            chk("status kept", 16'h002a, rd[15:0]);
            run({16'h1f80 + 16'(j), 96'h0, j ? 16'h0000 : 16'h3f3f});
            apb(1'b0, ADDR_STATUS, 16'h0000);
            chk("test bit", j ? 16'h0004 : 16'h003b, rd[15:0]);
        end
        test_done();
    end
endmodule : jcm_exec_test
